// [inc/psvb_pkg.sv]
// Package for the port and special variable bank: offsets, layouts, resets
package psvb_pkg;
    // -------------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------------
    localparam logic [11:0] OFF_INPUT_PORT = 12'h000;
    localparam logic [11:0] OFF_OUTPUT_LATCH = 12'h004;
    localparam logic [11:0] OFF_PIN_DIR = 12'h008;
    localparam logic [11:0] OFF_INFRA_KEY = 12'h00C;
    localparam logic [11:0] OFF_SCRATCH_PTR = 12'h010;
    localparam logic [11:0] OFF_SYS_EVENTS = 12'h014;
    localparam logic [11:0] OFF_IND_PLAIN = 12'h018;
    localparam logic [11:0] OFF_IND_INC = 12'h01C;
    localparam logic [11:0] OFF_IND_DEC = 12'h020;
    localparam logic [11:0] OFF_COPY_IN_OUT = 12'h024;
    localparam logic [11:0] OFF_INPUT_BIT = 12'h028;
    localparam logic [11:0] OFF_OUTPUT_BIT = 12'h02C;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h030;
    localparam logic [11:0] OFF_STORE_BASE = 12'h140;
    localparam logic [11:0] OFF_STORE_LAST = 12'h1FC;
    // -------------------------------------------------------------------
    // Storage byte addresses and flag positions
    // -------------------------------------------------------------------
    localparam int STORE_FIRST = 80;
    localparam int STORE_LAST = 127;
    localparam int FLAG_SER_RX = 5;
    localparam int FLAG_SLAVE_WR = 6;
    localparam int FLAG_TIMER_OV = 7;
    // -------------------------------------------------------------------
    // Reset value and response codes
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : psvb_pkg

// [hdl/psvb_bank.sv]
// Port, direction, scratchpad pointer, system flags and storage bank
`timescale 1ns/1ps
`default_nettype none
module psvb_bank
    import psvb_pkg::*;
#(
    parameter logic [7:0] IN_PIN_MASK = 8'hFF,
    parameter logic [7:0] OUT_PIN_MASK = 8'hFF,
    parameter logic [7:0] DIR_PIN_MASK = 8'hFF,
    parameter int SCRATCH_DEPTH = 128
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] port_in,
    output logic [7:0] port_out,
    output logic [7:0] port_dir,
    input wire logic serial_rx_event,
    input wire logic slave_write_event,
    input wire logic timer_overflow_event,
    output logic irq
);
    // -------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------
    if (SCRATCH_DEPTH != 128) begin : g_bad_depth
        $error("psvb_bank: scratchpad depth must be 128");
    end

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    logic [7:0] out_q;
    logic [7:0] dir_q;
    logic [7:0] infra_q;
    logic [7:0] ptr_q;
    logic [7:0] flags_q;
    logic [7:0] mask_q;
    logic [7:0] scratch_mem [0:SCRATCH_DEPTH-1];
    logic [7:0] store_mem [STORE_FIRST:STORE_LAST];
    logic aw_hold_q;
    logic w_hold_q;
    logic [11:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;

    // Word offset to storage byte address; valid only when in range
    function automatic logic store_hit(input logic [11:0] a);
        store_hit = (a >= OFF_STORE_BASE) && (a <= OFF_STORE_LAST);
    endfunction : store_hit

    function automatic logic [6:0] store_idx(input logic [11:0] a);
        store_idx = a[8:2];
    endfunction : store_idx

    function automatic logic known(input logic [11:0] a);
        unique case (a)
            OFF_INPUT_PORT, OFF_OUTPUT_LATCH, OFF_PIN_DIR, OFF_INFRA_KEY,
            OFF_SCRATCH_PTR, OFF_SYS_EVENTS, OFF_IND_PLAIN, OFF_IND_INC,
            OFF_IND_DEC, OFF_COPY_IN_OUT, OFF_INPUT_BIT, OFF_OUTPUT_BIT,
            OFF_IRQ_MASK: known = 1'b1;
            default: known = store_hit(a);
        endcase
    endfunction : known

    // -------------------------------------------------------------------
    // Write channel: address and data taken in either order
    // -------------------------------------------------------------------
    logic wr_go;
    assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            awaddr_q <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
        end else if (wr_go) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_hold_q <= 1'b0;
            wbyte_q <= RST_BYTE;
            wlane_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready)
                && !s_axi_bvalid;
            s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready)
                && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Byte lane 0 carries all data; a write without it changes nothing
    logic wr_en;
    assign wr_en = wr_go && wlane_q;

    // -------------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------------
    logic rd_go;
    logic [11:0] raddr;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign raddr = {s_axi_araddr[11:2], 2'b00};

    // Indirect accesses move the pointer, so bus reads and writes of them
    // must not land in the same cycle; reads wait while a write is pending.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
        end else begin
            // A write whose halves are held or being taken may commit next
            // cycle; holding arready low here keeps the pointer step of a
            // read from ever meeting that of a write.
            s_axi_arready <= !s_axi_rvalid && !rd_go && !wr_go
                && !aw_hold_q && !w_hold_q
                && !(s_axi_awvalid && s_axi_awready)
                && !(s_axi_wvalid && s_axi_wready);
        end
    end

    logic [7:0] rbyte;
    always_comb begin
        rbyte = RST_BYTE;
        unique case (raddr)
            OFF_INPUT_PORT: rbyte = port_in & IN_PIN_MASK;
            OFF_PIN_DIR: rbyte = dir_q & DIR_PIN_MASK;
            OFF_INFRA_KEY: rbyte = infra_q;
            OFF_SCRATCH_PTR: rbyte = ptr_q;
            OFF_SYS_EVENTS: rbyte = flags_q;
            OFF_IRQ_MASK: rbyte = mask_q;
            OFF_IND_PLAIN, OFF_IND_INC, OFF_IND_DEC: begin
                rbyte = scratch_mem[ptr_q[6:0]];
            end
            default: begin
                if (store_hit(raddr)) begin
                    rbyte = store_mem[store_idx(raddr)];
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (known(raddr) && raddr != OFF_OUTPUT_LATCH &&
                raddr != OFF_OUTPUT_BIT && raddr != OFF_COPY_IN_OUT)
                ? RESP_OKAY : RESP_SLVERR;
            if (raddr == OFF_INPUT_BIT) begin
                // No pin index is decoded here: a single input bit read
                // returns every bit at its own place, and software picks
                // the one it wants; missing pins are masked to zero
                s_axi_rdata <= {24'h000000, port_in & IN_PIN_MASK};
            end else begin
                s_axi_rdata <= {24'h000000, rbyte};
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Port, direction, spare byte and interrupt mask
    // -------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_q <= RST_BYTE;
        end else if (wr_en) begin
            if (awaddr_q == OFF_OUTPUT_LATCH) begin
                out_q <= wbyte_q & OUT_PIN_MASK;
            end else if (awaddr_q == OFF_COPY_IN_OUT) begin
                out_q <= port_in & IN_PIN_MASK & OUT_PIN_MASK;
            end else if (awaddr_q == OFF_OUTPUT_BIT) begin
                // Data bit 3 is the level, bits 2:0 pick the pin
                if (OUT_PIN_MASK[wbyte_q[2:0]]) begin
                    out_q[wbyte_q[2:0]] <= wbyte_q[3];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_q <= RST_BYTE;
            infra_q <= RST_BYTE;
            mask_q <= RST_BYTE;
        end else if (wr_en) begin
            if (awaddr_q == OFF_PIN_DIR) begin
                dir_q <= wbyte_q & DIR_PIN_MASK;
            end
            if (awaddr_q == OFF_INFRA_KEY) begin
                infra_q <= wbyte_q;
            end
            if (awaddr_q == OFF_IRQ_MASK) begin
                mask_q <= wbyte_q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_out <= RST_BYTE;
            port_dir <= RST_BYTE;
        end else begin
            port_out <= out_q;
            port_dir <= dir_q & DIR_PIN_MASK;
        end
    end

    // -------------------------------------------------------------------
    // Scratchpad pointer and indirect access
    // -------------------------------------------------------------------
    logic [11:0] ind_addr;
    logic ind_act;
    assign ind_addr = rd_go ? raddr : awaddr_q;
    assign ind_act = rd_go || wr_en;

    // A direct pointer write takes priority over any indirect step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_q <= RST_BYTE;
        end else if (wr_en && awaddr_q == OFF_SCRATCH_PTR) begin
            ptr_q <= wbyte_q;
        end else if (ind_act && ind_addr == OFF_IND_INC) begin
            ptr_q <= ptr_q + 8'h01;
        end else if (ind_act && ind_addr == OFF_IND_DEC) begin
            ptr_q <= ptr_q - 8'h01;
        end
    end

    // The pointer wraps within the 128-byte scratchpad by dropping bit 7
    always_ff @(posedge clk) begin
        if (wr_en && (awaddr_q == OFF_IND_PLAIN || awaddr_q == OFF_IND_INC
                || awaddr_q == OFF_IND_DEC)) begin
            scratch_mem[ptr_q[6:0]] <= wbyte_q;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en && store_hit(awaddr_q)) begin
            store_mem[store_idx(awaddr_q)] <= wbyte_q;
        end
    end

    // -------------------------------------------------------------------
    // System flags and interrupt
    // -------------------------------------------------------------------
    logic [7:0] hw_set;
    assign hw_set = {timer_overflow_event, slave_write_event,
        serial_rx_event, 5'b00000};

    // Software writes the byte as plain storage; hardware set wins a clash
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q <= RST_BYTE;
        end else if (wr_en && awaddr_q == OFF_SYS_EVENTS) begin
            flags_q <= wbyte_q | hw_set;
        end else begin
            flags_q <= flags_q | hw_set;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags_q & mask_q);
        end
    end
endmodule : psvb_bank
`default_nettype wire

// [tb/psvb_bank_sva.sv]
// Bus handshake and port drive checks for the port and variable bank
`timescale 1ns/1ps
`default_nettype none
module psvb_bank_sva
    import psvb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_dir
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // -------------------------------------------------------------------
    // Sequences
    // -------------------------------------------------------------------
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_at(logic [11:0] a);
        s_wr_taken ##0 (s_axi_awaddr == a && s_axi_wstrb[0]);
    endsequence
    sequence s_rd_at(logic [11:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    // -------------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------------
    chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read data missing");
    chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write response dropped");
    chk_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
        else $error("upper read bits not zero");
    chk_no_overlap: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_latch_drive: assert property (s_wr_at(OFF_OUTPUT_LATCH)
        |-> ##3 port_out == $past(s_axi_wdata[7:0], 3))
        else $error("output pins do not follow latch");
    chk_dir_drive: assert property (s_wr_at(OFF_PIN_DIR)
        |-> ##3 port_dir == $past(s_axi_wdata[7:0], 3))
        else $error("direction pins do not follow write");
    chk_latch_unread: assert property (s_rd_at(OFF_OUTPUT_LATCH)
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 0)
        else $error("write-only latch was readable");
endmodule : psvb_bank_sva
bind psvb_bank psvb_bank_sva u_sva (.*);
`default_nettype wire

// [tb/psvb_bank_tb_top.sv]
// Self-checking bench for the port and variable bank
`timescale 1ns/1ps
`default_nettype none
module psvb_bank_tb_top
    import psvb_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] port_in = 8'h00, port_out, port_dir;
    logic serial_rx_event = 0, slave_write_event = 0;
    logic timer_overflow_event = 0;
    int error_cnt = 0, checks = 0;
    psvb_bank uut (.*);
    initial begin
        forever #4 clk = ~clk;
    end
    // -------------------------------------------------------------------
    // Bus and compare tasks
    // -------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic a_ok;
        logic w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge clk);
            a_ok = a_ok | (s_axi_awready === 1'b1);
            w_ok = w_ok | (s_axi_wready === 1'b1);
            if (a_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                      input logic [1:0] exp_r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        chk(d, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, exp_r});
    endtask : rd
    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic t_port;
        port_in <= 8'hC3;
        wr(OFF_OUTPUT_LATCH, 32'h0000005A);
        @(posedge clk);
        chk({24'h0, port_out}, 32'h5A);
        rd(OFF_INPUT_PORT, 32'hC3, RESP_OKAY);
        rd(OFF_OUTPUT_LATCH, 32'h0, RESP_SLVERR);
        port_in <= 8'h96;
        wr(OFF_COPY_IN_OUT, 32'h0);
        @(posedge clk);
        chk({24'h0, port_out}, 32'h96);
        $display("port test done");
    endtask : t_port
    task automatic t_bits;
        wr(OFF_OUTPUT_LATCH, 32'h0);
        wr(OFF_OUTPUT_BIT, 32'h0000000D);
        wr(OFF_OUTPUT_BIT, 32'h0000000F);
        @(posedge clk);
        chk({24'h0, port_out}, 32'hA0);
        wr(OFF_OUTPUT_BIT, 32'h00000005);
        @(posedge clk);
        chk({24'h0, port_out}, 32'h80);
        rd(OFF_INPUT_BIT, 32'h96, RESP_OKAY);
        wr(OFF_PIN_DIR, 32'h00000016);
        @(posedge clk);
        chk({24'h0, port_dir}, 32'h16);
        rd(OFF_PIN_DIR, 32'h16, RESP_OKAY);
        $display("bit and direction test done");
    endtask : t_bits
    task automatic t_ptr;
        wr(OFF_SCRATCH_PTR, 32'h7F);
        wr(OFF_IND_INC, 32'h11);
        rd(OFF_SCRATCH_PTR, 32'h80, RESP_OKAY);
        wr(OFF_IND_DEC, 32'h22);
        rd(OFF_SCRATCH_PTR, 32'h7F, RESP_OKAY);
        rd(OFF_IND_PLAIN, 32'h11, RESP_OKAY);
        rd(OFF_SCRATCH_PTR, 32'h7F, RESP_OKAY);
        rd(OFF_IND_INC, 32'h11, RESP_OKAY);
        rd(OFF_IND_DEC, 32'h22, RESP_OKAY);
        rd(OFF_SCRATCH_PTR, 32'h7F, RESP_OKAY);
        $display("pointer test done");
    endtask : t_ptr
    task automatic t_flags;
        wr(OFF_SYS_EVENTS, 32'h0);
        wr(OFF_IRQ_MASK, 32'h80);
        timer_overflow_event <= 1'b1;
        @(posedge clk);
        timer_overflow_event <= 1'b0;
        rd(OFF_SYS_EVENTS, 32'h80, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        serial_rx_event <= 1'b1;
        slave_write_event <= 1'b1;
        @(posedge clk);
        serial_rx_event <= 1'b0;
        slave_write_event <= 1'b0;
        rd(OFF_SYS_EVENTS, 32'hE0, RESP_OKAY);
        // Flags double as user bits, so a plain write clears the events
        wr(OFF_SYS_EVENTS, 32'h1F);
        rd(OFF_SYS_EVENTS, 32'h1F, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        $display("flag test done");
    endtask : t_flags
    task automatic t_store;
        wr(OFF_STORE_BASE, 32'h5C);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        wr(OFF_STORE_LAST, 32'hC5);
        rd(OFF_STORE_BASE, 32'h5C, RESP_OKAY);
        rd(OFF_STORE_LAST, 32'hC5, RESP_OKAY);
        rd(OFF_STORE_BASE - 12'h004, 32'h0, RESP_SLVERR);
        $display("storage test done");
    endtask : t_store
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_port();
        t_bits();
        t_ptr();
        t_flags();
        t_store();
        print_verdict();
    end
    // Whole run needs well under two hundred cycles; this bounds any hang
    initial begin
        #100us;
        error_cnt++;
        print_verdict();
    end
endmodule : psvb_bank_tb_top
`default_nettype wire
